// ==== verif/afh_host_model.sv ====
// host terminal model: issues one-clock command pulses to the handler
`timescale 1ns/1ps
`default_nettype none
module afh_host_model (
  input  wire logic clk,
  output logic      abort_cmd,
  output logic      fault_clear,
  output logic      user_fault_force,
  output logic      fault_event,
  output logic      warn_event
);
  initial begin
    {abort_cmd, fault_clear, user_fault_force, fault_event, warn_event} = 5'h00;
  end
  //////////////////////////////////////////////////////////////////////////////
  // one command line high for exactly one clock
  task issue(input logic [4:0] k);
    @(posedge clk);
    {abort_cmd, fault_clear, user_fault_force, fault_event, warn_event} <= k;
    @(posedge clk);
    {abort_cmd, fault_clear, user_fault_force, fault_event, warn_event} <= 5'h00;
  endtask : issue
endmodule : afh_host_model
`default_nettype wire

// ==== verif/testbench.sv ====
// self-checking bench of the abort and fault handler
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module testbench;
  typedef struct packed {
    logic       stop, hpol, cpol, opol;
    logic [1:0] resp;
    logic       hard, off;
  } afh_row_t;
  logic       clk, rst_b, ce, abort_pin, clr_pin, motion, cond, no_clr;
  logic [4:0] pulses;
  logic       stop, hpol, cpol, opol, abort_cmd, fault_clear, user_fault_force;
  logic       fault_event, warn_event, seq_halt, hard_halt, soft_halt;
  logic       motor_current_off, fault_out, msg_fault_send, msg_warn_send;
  logic [1:0] resp, msg;
  logic [3:0] idx;
  logic [7:0] ev_code, w_code, fault_code_query, hist_code, msg_code;
  int         fail_count, n_checks, n_seq, n_hard, n_soft, n_mf, n_mw;
  afh_row_t   r;
  afh_row_t   rows [4] = '{{1'h1, 1'h0, 1'h0, 1'h0, 2'h2, 1'h0, 1'h1},
                          {1'h0, 1'h1, 1'h1, 1'h1, 2'h1, 1'h1, 1'h0},
                          {1'h1, 1'h1, 1'h0, 1'h1, 2'h2, 1'h0, 1'h1},
                          {1'h0, 1'h0, 1'h1, 1'h0, 2'h1, 1'h1, 1'h0}};
  //////////////////////////////////////////////////////////////////////////////
  afh_host_model u_host (.clk(clk), .abort_cmd(abort_cmd),
    .fault_clear(fault_clear), .user_fault_force(user_fault_force),
    .fault_event(fault_event), .warn_event(warn_event));
  afh_top u_dut (.clk(clk), .rst_b(rst_b), .ce(ce), .abort_cmd(abort_cmd),
    .abort_pin(abort_pin), .fault_clear(fault_clear),
    .fault_clear_pin(clr_pin), .user_fault_force(user_fault_force),
    .fault_event(fault_event), .fault_event_code(ev_code),
    .fault_event_motion(motion), .fault_cond_active(cond),
    .fault_no_clear(no_clr), .warn_event(warn_event), .warn_code(w_code),
    .cfg_stop_action(stop), .cfg_halt_pol(hpol), .cfg_fault_response(resp),
    .cfg_clear_pol(cpol), .cfg_fault_out_pol(opol), .cfg_fault_message(msg),
    .hist_idx(idx), .seq_halt(seq_halt), .hard_halt(hard_halt),
    .soft_halt(soft_halt), .motor_current_off(motor_current_off),
    .fault_out(fault_out), .fault_code_query(fault_code_query),
    .hist_code(hist_code), .msg_fault_send(msg_fault_send),
    .msg_warn_send(msg_warn_send), .msg_code(msg_code));
  //////////////////////////////////////////////////////////////////////////////
  always #12.5 clk = ~clk;
  // pulse counters, cleared before each command; unknown pulses fail
  assign pulses = {seq_halt, hard_halt, soft_halt, msg_fault_send,
                   msg_warn_send};
  always @(posedge clk) begin
    if (rst_b === 1'h1) `CHK($isunknown(pulses), 1'h0)
    n_seq += seq_halt;
    n_hard += hard_halt;
    n_soft += soft_halt;
    n_mf += msg_fault_send;
    n_mw += msg_warn_send;
  end
  task tick(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : tick
  task do_reset;
    @(posedge clk) rst_b <= 1'h0;
    tick(3);
    `CHK(fault_out, 1'h0)
    `CHK(fault_code_query, 8'h00)
    @(posedge clk) rst_b <= 1'h1;
    tick(3);
  endtask : do_reset
  task cnt0;
    @(negedge clk);
    {n_seq, n_hard, n_soft, n_mf, n_mw} = '0;
  endtask : cnt0
  task fire(input logic [4:0] k);
    cnt0;
    u_host.issue(k);
    tick(4);
  endtask : fire
  task cnts(input int s, input int h, input int so, input int f, input int w);
    `CHK(n_seq, s)
    `CHK(n_hard, h)
    `CHK(n_soft, so)
    `CHK(n_mf, f)
    `CHK(n_mw, w)
  endtask : cnts
  task end_sim;
    if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #(25 * 20000);
    fail_count++;
    end_sim;
  end
  initial begin
    clk = 1'h0;
    rst_b = 1'h0;
    ce = 1'h1;
    {abort_pin, clr_pin, motion, cond, no_clr, stop, hpol, cpol, opol} = '0;
    {resp, msg, idx, ev_code, w_code} = '0;
    for (int i = 0; i < 4; i++) begin
      r = rows[i];
      @(posedge clk);
      {stop, hpol, cpol, opol, resp} <= {r.stop, r.hpol, r.cpol, r.opol, r.resp};
      {abort_pin, clr_pin, motion, ev_code} <= {r.hpol, r.cpol, 1'h1, 8'h23};
      do_reset;
      `CHK(fault_out, r.opol)
      cnt0;
      @(posedge clk) abort_pin <= ~r.hpol;
      tick(4);
      @(posedge clk) abort_pin <= r.hpol;
      cnts(1, r.hard, !r.hard, 0, 0);
      fire(5'h02);
      cnts(1, 1, 0, 0, 0);
      `CHK(motor_current_off, r.off)
      `CHK(fault_out, ~r.opol)
      @(posedge clk) clr_pin <= ~r.cpol;
      tick(4);
      @(posedge clk) clr_pin <= r.cpol;
      tick(3);
      `CHK(fault_code_query, 8'h00)
      `CHK(fault_out, r.opol)
    end
    // defaults except message select 1, then a late stop-action change that must not act
    @(posedge clk);
    {stop, hpol, cpol, opol, resp, msg} <= {4'h8, 2'h2, 2'h1};
    {abort_pin, clr_pin, w_code} <= {2'h0, 8'h31};
    do_reset;
    @(posedge clk) stop <= 1'h0;
    fire(5'h10);
    cnts(1, 0, 1, 0, 0);
    fire(5'h04);
    cnts(1, 1, 0, 1, 0);
    `CHK(fault_code_query, 8'hE0)
    `CHK(msg_code, 8'hE0)
    `CHK(hist_code, 8'hE0)
    fire(5'h01);
    cnts(0, 0, 0, 0, 0);
    @(posedge clk) msg <= 2'h2;
    fire(5'h01);
    cnts(0, 0, 0, 0, 1);
    fire(5'h01);
    cnts(0, 0, 0, 0, 0);
    @(posedge clk) w_code <= 8'h32;
    fire(5'h01);
    cnts(0, 0, 0, 0, 1);
    `CHK(msg_code, 8'h32)
    @(posedge clk) cond <= 1'h1;
    fire(5'h08);
    `CHK(fault_code_query, 8'hE0)
    `CHK(fault_out, 1'h1)
    @(posedge clk) cond <= 1'h0;
    fire(5'h08);
    `CHK(fault_code_query, 8'h00)
    `CHK(hist_code, 8'hE0)
    @(posedge clk);
    {motion, no_clr, ev_code, msg} <= {2'h1, 8'hFF, 2'h0};
    fire(5'h02);
    cnts(1, 1, 0, 0, 0);
    `CHK(fault_code_query, 8'hF2)
    `CHK(motor_current_off, 1'h0)
    `CHK(hist_code, 8'hF2)
    @(posedge clk) idx <= 4'h1;
    tick(2);
    `CHK(hist_code, 8'hE0)
    @(posedge clk) idx <= 4'hA;
    tick(2);
    `CHK(hist_code, 8'h00)
    // clock enable low: a forced fault must leave no trace
    @(posedge clk) ce <= 1'h0;
    fire(5'h04);
    @(posedge clk) {ce, idx} <= {1'h1, 4'h0};
    tick(2);
    cnts(0, 0, 0, 0, 0);
    `CHK(fault_code_query, 8'hF2)
    `CHK(hist_code, 8'hF2)
    fire(5'h08);
    `CHK(fault_code_query, 8'hF2)
    `CHK(fault_out, 1'h1)
    do_reset;
    `CHK(fault_code_query, 8'h00)
    end_sim;
  end
endmodule : testbench
`default_nettype wire

// ==== verilog/afh_hist_mem.sv ====
// ten-entry fault history, newest first, registered read
`timescale 1ns/1ps
`default_nettype none
`include "afh_map.svh"
module afh_hist_mem (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  input  wire logic       push,
  input  wire logic [7:0] push_code,
  input  wire logic [3:0] rd_idx,
  output logic      [7:0] rd_data
);
  logic [7:0] mem_q [`AFH_HIST_DEPTH];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `AFH_HIST_DEPTH; i++) mem_q[i] <= 8'h00;
    end else if (ce && push) begin
      mem_q[0] <= push_code;
      for (int i = 1; i < `AFH_HIST_DEPTH; i++) mem_q[i] <= mem_q[i-1];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= 8'h00;
    end else if (ce) begin
      rd_data <= (rd_idx < 4'(`AFH_HIST_DEPTH)) ? mem_q[rd_idx] : 8'h00;
    end
  end
endmodule : afh_hist_mem
`default_nettype wire

// ==== verilog/afh_map.svh ====
// constants of the abort and fault handler
`ifndef AFH_MAP_SVH
`define AFH_MAP_SVH
`define AFH_CODE_NONE      8'h00
`define AFH_CODE_MAX       8'hF2
`define AFH_CODE_USER      8'hE0
`define AFH_HIST_DEPTH     10
`define AFH_STOP_HARD      1'h0
`define AFH_STOP_SOFT      1'h1
`define AFH_STOP_RST       1'h1
`define AFH_POL_RST        1'h0
`define AFH_RESP_CUR_ON    2'h1
`define AFH_RESP_CUR_OFF   2'h2
`define AFH_RESP_RST       2'h2
`define AFH_MSG_NONE       2'h0
`define AFH_MSG_FAULT      2'h1
`define AFH_MSG_ALL        2'h2
`define AFH_MSG_RST        2'h0
`endif

// ==== verilog/afh_pin_level.sv ====
// polarity-corrected input level with rising-edge pulse
`timescale 1ns/1ps
`default_nettype none
module afh_pin_level (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic ce,
  input  wire logic pin,
  input  wire logic nc_sel,
  output logic      active,
  output logic      rise
);
  logic lvl_q;
  assign active = pin ^ nc_sel;
  assign rise   = active & ~lvl_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) lvl_q <= 1'b0;
    else if (ce) lvl_q <= active;
  end
endmodule : afh_pin_level
`default_nettype wire

// ==== verilog/afh_pkg.sv ====
// types of the abort and fault handler
package afh_pkg;
  typedef enum logic [1:0] {
    AFH_RUN   = 2'b00,
    AFH_FAULT = 2'b01,
    AFH_CLEAR = 2'b10
  } afh_state_t;
endpackage : afh_pkg

// ==== verilog/afh_top.sv ====
// abort and fault handler top
// Notes on behaviour
// - abort command ends any running sequence, immediate or from a sequence
// - stop action 0: abort gives a hard halt, as fast as possible
// - stop action 1: abort with no fault in the same cycle gives a soft halt, controlled deceleration
// - stop action defaults to 1; new value acts only after reset
// - abort input polarity: 0 normally open, 1 normally closed, default 0
// - query reports current fault code plus ten most recent faults
// - fault code is read-only, 00 to F2, 00 means no fault
// - reset clears current code and the history as well
// - motion fault stops all; response 1 current on, 2 current off
// - fault response applies only to motion-originated faults
// - fault clear returns to operation if the condition is gone
// - condition still present after clear: fault state re-entered
// - designated faults raised in run or fault state refuse to clear
// - fault-clear input polarity 0/1, default 0, acts after reset
// - fault output idles at its polarity, flips while faulted
// - message select 0 none, 1 faults, 2 faults and warnings; immediate
// - warning sent only when it differs from the last reported
// - user fault force enters fault state and halts sequences
`timescale 1ns/1ps
`default_nettype none
`include "afh_map.svh"
module afh_top (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  input  wire logic       abort_cmd,
  input  wire logic       abort_pin,
  input  wire logic       fault_clear,
  input  wire logic       fault_clear_pin,
  input  wire logic       user_fault_force,
  input  wire logic       fault_event,
  input  wire logic [7:0] fault_event_code,
  input  wire logic       fault_event_motion,
  input  wire logic       fault_cond_active,
  input  wire logic       fault_no_clear,
  input  wire logic       warn_event,
  input  wire logic [7:0] warn_code,
  input  wire logic       cfg_stop_action,
  input  wire logic       cfg_halt_pol,
  input  wire logic [1:0] cfg_fault_response,
  input  wire logic       cfg_clear_pol,
  input  wire logic       cfg_fault_out_pol,
  input  wire logic [1:0] cfg_fault_message,
  input  wire logic [3:0] hist_idx,
  output logic            seq_halt,
  output logic            hard_halt,
  output logic            soft_halt,
  output logic            motor_current_off,
  output logic            fault_out,
  output logic [7:0]      fault_code_query,
  output logic [7:0]      hist_code,
  output logic            msg_fault_send,
  output logic            msg_warn_send,
  output logic [7:0]      msg_code
);
  afh_pkg::afh_state_t state_q;
  logic       stop_act_q, halt_pol_q, clr_pol_q, out_pol_q;
  logic [1:0] resp_q;
  logic [7:0] code_q, last_warn_q;
  logic       warn_valid_q, motion_fault_q, no_clear_q;
  logic       abort_rise, clr_rise;
  logic       new_fault, clr_req, hist_push;
  logic [7:0] new_code, code_sat;

  ////////////////////////////////////////////////////////////////////
  // settings latched once after reset release
  logic cfg_taken_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_taken_q <= 1'b0;
      stop_act_q  <= `AFH_STOP_RST;
      halt_pol_q  <= `AFH_POL_RST;
      clr_pol_q   <= `AFH_POL_RST;
      out_pol_q   <= `AFH_POL_RST;
      resp_q      <= `AFH_RESP_RST;
    end else if (ce && !cfg_taken_q) begin
      cfg_taken_q <= 1'b1;
      stop_act_q  <= cfg_stop_action;
      halt_pol_q  <= cfg_halt_pol;
      clr_pol_q   <= cfg_clear_pol;
      out_pol_q   <= cfg_fault_out_pol;
      resp_q      <= cfg_fault_response;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // input pins
  afh_pin_level u_abort_pin (
    .clk    (clk),
    .rst_b  (rst_b),
    .ce     (ce & cfg_taken_q),
    .pin    (abort_pin),
    .nc_sel (halt_pol_q),
    .active (),
    .rise   (abort_rise)
  );
  afh_pin_level u_clear_pin (
    .clk    (clk),
    .rst_b  (rst_b),
    .ce     (ce & cfg_taken_q),
    .pin    (fault_clear_pin),
    .nc_sel (clr_pol_q),
    .active (),
    .rise   (clr_rise)
  );

  logic abort_req;
  assign abort_req = cfg_taken_q & (abort_cmd | abort_rise);
  assign clr_req   = cfg_taken_q & (fault_clear | clr_rise);
  assign new_fault = fault_event | user_fault_force;
  assign code_sat  = (fault_event_code > `AFH_CODE_MAX) ?
                     `AFH_CODE_MAX : fault_event_code;
  assign new_code  = fault_event ? code_sat : `AFH_CODE_USER;
  assign hist_push = ce & new_fault;

  ////////////////////////////////////////////////////////////////////
  // fault state machine
  // code held internally, read only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q        <= afh_pkg::AFH_RUN;
      code_q         <= `AFH_CODE_NONE;
      motion_fault_q <= 1'b0;
      no_clear_q     <= 1'b0;
    end else if (ce) begin
      unique case (state_q)
        afh_pkg::AFH_RUN: begin
          if (new_fault) begin
            state_q        <= afh_pkg::AFH_FAULT;
            code_q         <= new_code;
            motion_fault_q <= fault_event & fault_event_motion;
            no_clear_q     <= fault_event & fault_no_clear;
          end
        end
        afh_pkg::AFH_FAULT: begin
          if (new_fault) begin
            code_q         <= new_code;
            motion_fault_q <= motion_fault_q |
                              (fault_event & fault_event_motion);
            no_clear_q     <= no_clear_q | (fault_event & fault_no_clear);
          end else if (clr_req && !no_clear_q) begin
            state_q <= afh_pkg::AFH_CLEAR;
          end
        end
        afh_pkg::AFH_CLEAR: begin
          if (new_fault || fault_cond_active) begin
            state_q <= afh_pkg::AFH_FAULT;
            if (new_fault) code_q <= new_code;
          end else begin
            state_q        <= afh_pkg::AFH_RUN;
            code_q         <= `AFH_CODE_NONE;
            motion_fault_q <= 1'b0;
          end
        end
        default: state_q <= afh_pkg::AFH_FAULT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // history and query
  // ten-deep history beside current code
  afh_hist_mem u_hist (
    .clk       (clk),
    .rst_b     (rst_b),
    .ce        (ce),
    .push      (hist_push),
    .push_code (new_code),
    .rd_idx    (hist_idx),
    .rd_data   (hist_code)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) fault_code_query <= `AFH_CODE_NONE;
    else if (ce) fault_code_query <= code_q;
  end

  ////////////////////////////////////////////////////////////////////
  // halt outputs
  logic faulted;
  assign faulted = (state_q != afh_pkg::AFH_RUN);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seq_halt  <= 1'b0;
      hard_halt <= 1'b0;
      soft_halt <= 1'b0;
    end else if (ce) begin
      seq_halt  <= abort_req | new_fault;
      // hard halt on abort with stop action 0, and on any new fault
      hard_halt <= (abort_req & (stop_act_q == `AFH_STOP_HARD)) | new_fault;
      // soft halt on abort with stop action 1 and no new fault
      soft_halt <= abort_req & (stop_act_q == `AFH_STOP_SOFT) & ~new_fault;
    end
  end

  // current off only for response 2
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) motor_current_off <= 1'b0;
    else if (ce)
      motor_current_off <= faulted & motion_fault_q &
                           (resp_q == `AFH_RESP_CUR_OFF);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) fault_out <= `AFH_POL_RST;
    else if (ce) fault_out <= out_pol_q ^ faulted;
  end

  ////////////////////////////////////////////////////////////////////
  // automatic messages
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      msg_fault_send <= 1'b0;
      msg_warn_send  <= 1'b0;
      msg_code       <= 8'h00;
      last_warn_q    <= 8'h00;
      warn_valid_q   <= 1'b0;
    end else if (ce) begin
      msg_fault_send <= 1'b0;
      msg_warn_send  <= 1'b0;
      if (new_fault && cfg_fault_message != `AFH_MSG_NONE) begin
        msg_fault_send <= 1'b1;
        msg_code       <= new_code;
      end else if (warn_event && cfg_fault_message == `AFH_MSG_ALL &&
                   (!warn_valid_q || warn_code != last_warn_q)) begin
        msg_warn_send <= 1'b1;
        msg_code      <= warn_code;
        last_warn_q   <= warn_code;
        warn_valid_q  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  // hard abort
  a_abort_hard: assert property (@(posedge clk) disable iff (!rst_b)
    ce && abort_req && stop_act_q == `AFH_STOP_HARD |=> hard_halt && seq_halt)
    else $error("hard abort missing");
  a_abort_soft: assert property (@(posedge clk) disable iff (!rst_b)
    ce && abort_req && !new_fault && stop_act_q == `AFH_STOP_SOFT
    |=> soft_halt && !hard_halt) else $error("soft abort missing");
  a_user_force: assert property (@(posedge clk) disable iff (!rst_b)
    ce && user_fault_force |=> state_q == afh_pkg::AFH_FAULT && seq_halt)
    else $error("user fault not entered");
  a_no_clear: assert property (@(posedge clk) disable iff (!rst_b)
    ce && state_q == afh_pkg::AFH_FAULT && no_clear_q
    |=> state_q == afh_pkg::AFH_FAULT) else $error("fault was cleared");
  sequence s_clear_ok;
    ce && state_q == afh_pkg::AFH_CLEAR && !new_fault && !fault_cond_active;
  endsequence
  a_clear_code: assert property (@(posedge clk) disable iff (!rst_b)
    s_clear_ok |=> code_q == `AFH_CODE_NONE ##1 fault_code_query == 8'h00)
    else $error("code not zero after clear");
  a_refault: assert property (@(posedge clk) disable iff (!rst_b)
    ce && state_q == afh_pkg::AFH_CLEAR && fault_cond_active
    |=> state_q == afh_pkg::AFH_FAULT) else $error("no refault");
  a_fault_out: assert property (@(posedge clk) disable iff (!rst_b)
    ce && cfg_taken_q |=> fault_out == (out_pol_q ^ $past(faulted)))
    else $error("fault output level wrong");
  a_code_range: assert property (@(posedge clk) disable iff (!rst_b)
    code_q <= `AFH_CODE_MAX) else $error("code beyond range");
  a_warn_repeat: assert property (@(posedge clk) disable iff (!rst_b)
    ce && warn_valid_q && warn_code == last_warn_q |=> !msg_warn_send)
    else $error("repeated warning sent");
  // current stays on for response 1
  a_current_on: assert property (@(posedge clk) disable iff (!rst_b)
    resp_q == `AFH_RESP_CUR_ON |-> !motor_current_off)
    else $error("current off with response 1");
  // current off for motion fault with response 2
  a_current_off: assert property (@(posedge clk) disable iff (!rst_b)
    ce && faulted && motion_fault_q && resp_q == `AFH_RESP_CUR_OFF
    |=> motor_current_off) else $error("current on with response 2");
  a_msg_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    ce && cfg_fault_message == `AFH_MSG_NONE
    |=> !msg_fault_send && !msg_warn_send)
    else $error("message sent with select 0");
endmodule : afh_top
`default_nettype wire
